// >>> rtl/cfg_port_pkg.sv
// Constants shared by the serial configuration port and its register bank
// Summary of operation
// - Chip select falling starts a new word
// - First sixteen rising clock edges sample data
// - Edges after sixteenth shift nothing; a falling one releases data output
// - Chip select high ends transaction, rearms
// - Word: flag, address MSB first, data MSB first
// - Flag low writes data to addressed register
// - Flag high shifts addressed register out
// - Read leaves register unchanged, ignores input
// - Data output only pulls low or releases
// - Bit 7 at address 0 resets registers
// - Reset bit clears itself after reset
// - Address 0 reads back as all ones
// - Power-down bit 2 selects keep-alive state
// - Address 9 three-bit field selects pattern
// - Minus-one fields hold quantity minus one
// - Address 2 holds clock, overflow, stabilizer bits
package cfg_port_pkg;
	localparam int WORD_BITS = 16;
	localparam int ADDR_BITS = 7;
	localparam int DATA_BITS = 8;
	localparam int CNT_BITS = 5;
	localparam logic [CNT_BITS-1:0] CNT_WORD = 5'h10;
	localparam logic [CNT_BITS-1:0] CNT_ADDR_DONE = 5'h08;
	localparam int NUM_REGS = 11;
	localparam int FLAG_POS = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 8;
	localparam int RST_TRIG_BIT = 7;
	localparam logic [ADDR_BITS-1:0] ADDR_SOFT_RESET = 7'h00;
	localparam logic [ADDR_BITS-1:0] ADDR_POWER_DOWN = 7'h01;
	localparam logic [ADDR_BITS-1:0] ADDR_CLK_OPTS = 7'h02;
	localparam logic [ADDR_BITS-1:0] ADDR_DEV_NUM = 7'h03;
	localparam logic [ADDR_BITS-1:0] ADDR_BANK_NUM = 7'h04;
	localparam logic [ADDR_BITS-1:0] ADDR_LANES = 7'h05;
	localparam logic [ADDR_BITS-1:0] ADDR_MFRAME = 7'h06;
	localparam logic [ADDR_BITS-1:0] ADDR_LINK_MODE = 7'h07;
	localparam logic [ADDR_BITS-1:0] ADDR_SUBCLASS = 7'h08;
	localparam logic [ADDR_BITS-1:0] ADDR_PATTERN = 7'h09;
	localparam logic [ADDR_BITS-1:0] ADDR_SWING = 7'h0A;
	localparam logic [DATA_BITS-1:0] READ_ALL_ONES = 8'hFF;
	localparam logic [DATA_BITS-1:0] READ_UNMAPPED = 8'h00;
	// Writable bit masks; unused bits read as zero
	localparam logic [DATA_BITS-1:0] MASK_POWER_DOWN = 8'h0F;
	localparam logic [DATA_BITS-1:0] MASK_CLK_OPTS = 8'h07;
	localparam logic [DATA_BITS-1:0] MASK_DEV_NUM = 8'hFF;
	localparam logic [DATA_BITS-1:0] MASK_BANK_NUM = 8'h0F;
	localparam logic [DATA_BITS-1:0] MASK_LANES = 8'h07;
	localparam logic [DATA_BITS-1:0] MASK_MFRAME = 8'h1F;
	localparam logic [DATA_BITS-1:0] MASK_LINK_MODE = 8'h3B;
	localparam logic [DATA_BITS-1:0] MASK_SUBCLASS = 8'hFF;
	localparam logic [DATA_BITS-1:0] MASK_PATTERN = 8'h07;
	localparam logic [DATA_BITS-1:0] MASK_SWING = 8'h03;
	// Defaults
	localparam logic [DATA_BITS-1:0] DEF_POWER_DOWN = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_CLK_OPTS = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_DEV_NUM = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_BANK_NUM = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_LANES = 8'h01;
	localparam logic [DATA_BITS-1:0] DEF_MFRAME = 8'h0F;
	localparam logic [DATA_BITS-1:0] DEF_LINK_MODE = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_SUBCLASS = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_PATTERN = 8'h00;
	localparam logic [DATA_BITS-1:0] DEF_SWING = 8'h00;
	// Field positions
	localparam int PD_SLEEP_BIT = 3;
	localparam int PD_NAP_BIT = 2;
	localparam int PD_B_BIT = 1;
	localparam int PD_A_BIT = 0;
	localparam int CK_HALF_BIT = 2;
	localparam int CK_OVF_BIT = 1;
	localparam int CK_DCS_BIT = 0;
	localparam int LM_LAS_BIT = 5;
	localparam int LM_LAM_BIT = 4;
	localparam int LM_FAM_BIT = 3;
	localparam int LM_RST_BIT = 1;
	localparam int LM_SCR_BIT = 0;
	localparam int PAT_BITS = 3;
	typedef enum logic [2:0] {
		PAT_NORMAL = 3'h0,
		PAT_K28_5 = 3'h1,
		PAT_K28_7 = 3'h2,
		PAT_D21_5 = 3'h3,
		PAT_PRBS15 = 3'h4,
		PAT_ALIGN_SEQ = 3'h5,
		PAT_LONG_TRANSPORT = 3'h6,
		PAT_MOD_RPAT = 3'h7
	} pattern_t;
endpackage

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for a group of external pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Pins in, synchronised levels out
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] meta_r;

	// First stage is read only by the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= INIT;
			pin_sync_out <= INIT;
		end else begin
			meta_r <= pin_in;
			pin_sync_out <= meta_r;
		end
	end
endmodule // pin_sync
`default_nettype wire

// >>> rtl/cfg_reg_bank.sv
// Mode-control register bank with registered read port
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_bank
	import cfg_port_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Write port
	input wire logic wr_en,
	input wire logic soft_rst,
	input wire logic [ADDR_BITS-1:0] wr_addr,
	input wire logic [DATA_BITS-1:0] wr_data,
	// Read port, data registered
	input wire logic [ADDR_BITS-1:0] rd_addr,
	output logic [DATA_BITS-1:0] rd_data,
	// Stored contents
	output logic [DATA_BITS-1:0] regs_q [1:NUM_REGS-1]
);
	function automatic logic [DATA_BITS-1:0] reg_mask(input int idx);
		case (idx)
			1: reg_mask = MASK_POWER_DOWN;
			2: reg_mask = MASK_CLK_OPTS;
			3: reg_mask = MASK_DEV_NUM;
			4: reg_mask = MASK_BANK_NUM;
			5: reg_mask = MASK_LANES;
			6: reg_mask = MASK_MFRAME;
			7: reg_mask = MASK_LINK_MODE;
			8: reg_mask = MASK_SUBCLASS;
			9: reg_mask = MASK_PATTERN;
			default: reg_mask = MASK_SWING;
		endcase
	endfunction

	function automatic logic [DATA_BITS-1:0] reg_default(input int idx);
		case (idx)
			1: reg_default = DEF_POWER_DOWN;
			2: reg_default = DEF_CLK_OPTS;
			3: reg_default = DEF_DEV_NUM;
			4: reg_default = DEF_BANK_NUM;
			5: reg_default = DEF_LANES;
			6: reg_default = DEF_MFRAME;
			7: reg_default = DEF_LINK_MODE;
			8: reg_default = DEF_SUBCLASS;
			9: reg_default = DEF_PATTERN;
			default: reg_default = DEF_SWING;
		endcase
	endfunction

	genvar g;
	generate
		for (g = 1; g < NUM_REGS; g++) begin : g_reg
			always_ff @(posedge clk) begin
				if (sys_rst || soft_rst) begin
					regs_q[g] <= reg_default(g);
				end else if (wr_en && wr_addr == ADDR_BITS'(g)) begin
					regs_q[g] <= wr_data & reg_mask(g);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rd_data <= READ_UNMAPPED;
		end else if (rd_addr == ADDR_SOFT_RESET) begin
			rd_data <= READ_ALL_ONES;
		end else if (rd_addr < ADDR_BITS'(NUM_REGS)) begin
			rd_data <= regs_q[rd_addr];
		end else begin
			rd_data <= READ_UNMAPPED;
		end
	end
endmodule // cfg_reg_bank
`default_nettype wire

// >>> rtl/adc_spi_config_port.sv
// Serial configuration port: shifter, decode, soft reset and control outputs
`timescale 1ns/1ps
`default_nettype none
module adc_spi_config_port
	import cfg_port_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial pins from the host
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	// Open-drain serial data output
	output logic sdo_o,
	output logic sdo_oe,
	// Power control
	output logic converter_sleep,
	output logic channels_nap,
	output logic channel_b_off,
	output logic channel_a_off,
	// Clock options
	output logic clock_halving_select,
	output logic overflow_output_enable,
	output logic duty_stabilizer_enable,
	// Link parameters
	output logic [7:0] link_device_number,
	output logic [3:0] link_bank_number,
	output logic [2:0] lane_count_m1,
	output logic [4:0] frames_per_multiframe_m1,
	output logic align_sequence_off,
	output logic lane_monitor_off,
	output logic frame_monitor_off,
	output logic divider_resync_off,
	output logic scrambler_on,
	output logic [7:0] link_subclass_options,
	// Pattern and swing
	output logic [2:0] test_pattern_select,
	output logic [1:0] output_swing_select,
	// Soft reset in progress
	output logic soft_reset_busy
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_DONE
	} xfer_state_t;

	logic cs_n_s, sck_s, sdi_s;
	logic sck_prev_r, cs_prev_r;
	logic sck_rise, sck_fall, cs_fall, cs_rise;
	xfer_state_t state_r;
	logic [CNT_BITS-1:0] bit_cnt_r;
	logic [WORD_BITS-1:0] shift_r;
	logic [WORD_BITS-1:0] word_nxt;
	logic is_read_r;
	logic [ADDR_BITS-1:0] addr_r;
	logic [DATA_BITS-1:0] rd_data;
	logic [DATA_BITS-1:0] out_shift_r;
	logic wr_en_r;
	logic [ADDR_BITS-1:0] wr_addr_r;
	logic [DATA_BITS-1:0] wr_data_r;
	logic soft_rst_r;
	logic load_out_r;
	logic load_dly_r;
	logic hdr_edge, last_edge;
	logic [DATA_BITS-1:0] regs_q [1:NUM_REGS-1];

	// True on the rising serial edge that completes bit number last of the word
	function automatic logic edge_done(input xfer_state_t st, input logic rise, input logic [CNT_BITS-1:0] cnt,
		input logic [CNT_BITS-1:0] last);
		edge_done = st == ST_SHIFT && rise && cnt == last - 1'b1;
	endfunction

	// Pins cross into the clk domain before any logic looks at them
	pin_sync #(
		.WIDTH(3),
		.INIT(3'h4)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_in({cs_n, sck, sdi}),
		.pin_sync_out({cs_n_s, sck_s, sdi_s})
	);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sck_prev_r <= 1'b0;
			cs_prev_r <= 1'b1;
		end else begin
			sck_prev_r <= sck_s;
			cs_prev_r <= cs_n_s;
		end
	end

	assign sck_rise = sck_s && !sck_prev_r && !cs_n_s;
	assign sck_fall = !sck_s && sck_prev_r && !cs_n_s;
	assign cs_fall = !cs_n_s && cs_prev_r;
	assign cs_rise = cs_n_s && !cs_prev_r;
	assign word_nxt = {shift_r[WORD_BITS-2:0], sdi_s};
	// Edges count only while selected, so a clock toggling between words is harmless
	assign hdr_edge = edge_done(state_r, sck_rise, bit_cnt_r, CNT_ADDR_DONE);
	assign last_edge = edge_done(state_r, sck_rise, bit_cnt_r, CNT_WORD);

	// Transaction sequencing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= '0;
			shift_r <= '0;
		end else if (cs_rise || cs_n_s) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= '0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (cs_fall) begin
						state_r <= ST_SHIFT;
						bit_cnt_r <= '0;
					end
				end
				ST_SHIFT: begin
					if (sck_rise) begin
						shift_r <= word_nxt;
						bit_cnt_r <= bit_cnt_r + 1'b1;
						if (last_edge) begin
							state_r <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state_r <= ST_DONE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Read flag and address latch once the header is in
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			is_read_r <= 1'b0;
			addr_r <= '0;
			load_out_r <= 1'b0;
			load_dly_r <= 1'b0;
		end else begin
			load_out_r <= 1'b0;
			// Bank read port is registered, so its data trails the new address by one clock
			load_dly_r <= load_out_r;
			if (cs_n_s) begin
				is_read_r <= 1'b0;
			end else if (hdr_edge) begin
				is_read_r <= word_nxt[ADDR_BITS];
				addr_r <= word_nxt[ADDR_BITS-1:0];
				load_out_r <= 1'b1;
			end
		end
	end

	// Write commit on the sixteenth edge of a write word
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_en_r <= 1'b0;
			wr_addr_r <= '0;
			wr_data_r <= '0;
			soft_rst_r <= 1'b0;
		end else begin
			wr_en_r <= 1'b0;
			soft_rst_r <= 1'b0;
			if (!cs_n_s && last_edge && !word_nxt[FLAG_POS]) begin
				wr_en_r <= 1'b1;
				wr_addr_r <= word_nxt[ADDR_MSB:ADDR_LSB];
				wr_data_r <= word_nxt[DATA_BITS-1:0];
				// Reset trigger is a one-cycle pulse; address 0 still reads back as all ones afterwards
				soft_rst_r <= word_nxt[ADDR_MSB:ADDR_LSB] == ADDR_SOFT_RESET
					&& word_nxt[RST_TRIG_BIT];
			end
		end
	end

	cfg_reg_bank u_bank (
		.clk(clk),
		.sys_rst(sys_rst),
		.wr_en(wr_en_r),
		.soft_rst(soft_rst_r),
		.wr_addr(wr_addr_r),
		.wr_data(wr_data_r),
		.rd_addr(addr_r),
		.rd_data(rd_data),
		.regs_q(regs_q)
	);

	// Read data: first bit shown after the eighth edge falls, later bits on each falling edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_shift_r <= READ_ALL_ONES;
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_o <= 1'b0;
			if (cs_n_s || !is_read_r) begin
				sdo_oe <= 1'b0;
				out_shift_r <= READ_ALL_ONES;
			end else if (load_dly_r) begin
				out_shift_r <= rd_data;
			end else if (sck_fall && state_r == ST_SHIFT) begin
				// Ones shift in behind the data, so any extra bit reads as released
				sdo_oe <= !out_shift_r[DATA_BITS-1];
				out_shift_r <= {out_shift_r[DATA_BITS-2:0], 1'b1};
			end else if (state_r == ST_DONE && sck_fall) begin
				sdo_oe <= 1'b0;
			end
		end
	end

	// Control outputs mirror the stored registers through flops, one block per register or register pair
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			converter_sleep <= 1'b0;
			channels_nap <= 1'b0;
			channel_b_off <= 1'b0;
			channel_a_off <= 1'b0;
		end else begin
			converter_sleep <= regs_q[ADDR_POWER_DOWN][PD_SLEEP_BIT];
			channels_nap <= regs_q[ADDR_POWER_DOWN][PD_NAP_BIT];
			channel_b_off <= regs_q[ADDR_POWER_DOWN][PD_B_BIT];
			channel_a_off <= regs_q[ADDR_POWER_DOWN][PD_A_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clock_halving_select <= 1'b0;
			overflow_output_enable <= 1'b0;
			duty_stabilizer_enable <= 1'b0;
		end else begin
			clock_halving_select <= regs_q[ADDR_CLK_OPTS][CK_HALF_BIT];
			overflow_output_enable <= regs_q[ADDR_CLK_OPTS][CK_OVF_BIT];
			duty_stabilizer_enable <= regs_q[ADDR_CLK_OPTS][CK_DCS_BIT];
		end
	end

	// Busy trails the reset pulse, so whoever sees it finds the defaults already stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_reset_busy <= 1'b0;
		end else begin
			soft_reset_busy <= soft_rst_r;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_device_number <= DEF_DEV_NUM;
			link_bank_number <= DEF_BANK_NUM[3:0];
		end else begin
			link_device_number <= regs_q[ADDR_DEV_NUM];
			link_bank_number <= regs_q[ADDR_BANK_NUM][3:0];
		end
	end

	// Minus-one coded fields pass through raw; the link logic adds the one back
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lane_count_m1 <= DEF_LANES[2:0];
			frames_per_multiframe_m1 <= DEF_MFRAME[4:0];
		end else begin
			lane_count_m1 <= regs_q[ADDR_LANES][2:0];
			frames_per_multiframe_m1 <= regs_q[ADDR_MFRAME][4:0];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			align_sequence_off <= 1'b0;
			lane_monitor_off <= 1'b0;
			frame_monitor_off <= 1'b0;
			divider_resync_off <= 1'b0;
			scrambler_on <= 1'b0;
		end else begin
			align_sequence_off <= regs_q[ADDR_LINK_MODE][LM_LAS_BIT];
			lane_monitor_off <= regs_q[ADDR_LINK_MODE][LM_LAM_BIT];
			frame_monitor_off <= regs_q[ADDR_LINK_MODE][LM_FAM_BIT];
			divider_resync_off <= regs_q[ADDR_LINK_MODE][LM_RST_BIT];
			scrambler_on <= regs_q[ADDR_LINK_MODE][LM_SCR_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_subclass_options <= DEF_SUBCLASS;
		end else begin
			link_subclass_options <= regs_q[ADDR_SUBCLASS];
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			test_pattern_select <= PAT_NORMAL;
			output_swing_select <= DEF_SWING[1:0];
		end else begin
			test_pattern_select <= regs_q[ADDR_PATTERN][PAT_BITS-1:0];
			output_swing_select <= regs_q[ADDR_SWING][1:0];
		end
	end
endmodule // adc_spi_config_port
`default_nettype wire

// >>> sim/adc_spi_config_port_chk.sv
// Concurrent checks on the configuration port's pins
`timescale 1ns/1ps
`default_nettype none
module adc_spi_config_port_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Serial pins
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	// Control outputs
	input wire logic converter_sleep,
	input wire logic channels_nap,
	input wire logic clock_halving_select,
	input wire logic [2:0] lane_count_m1,
	input wire logic [4:0] frames_per_multiframe_m1,
	input wire logic [2:0] test_pattern_select,
	input wire logic [7:0] link_device_number,
	input wire logic soft_reset_busy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	property p_sdo_low;
		sdo_o == 1'b0;
	endproperty
	a_sdo_low: assert property (p_sdo_low) else $error("sdo value driven high");
	property p_release_idle;
		cs_n [*5] |-> !sdo_oe;
	endproperty
	a_release_idle: assert property (p_release_idle) else $error("sdo pulled while deselected");
	property p_oe_in_frame;
		sdo_oe |-> !$past(cs_n, 4);
	endproperty
	a_oe_in_frame: assert property (p_oe_in_frame) else $error("sdo pulled outside a frame");
	// Read bits must move on falling edges so they stand at the next rise
	property p_oe_after_fall;
		$rose(sdo_oe) |-> !sck && !$past(sck, 2);
	endproperty
	a_oe_after_fall: assert property (p_oe_after_fall) else $error("sdo changed near a rising edge");
	property p_reset_defaults;
		$fell(sys_rst) |-> lane_count_m1 == 3'h1 && frames_per_multiframe_m1 == 5'h0F && !clock_halving_select && !channels_nap;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("controls not at defaults");
	property p_soft_defaults;
		soft_reset_busy |=> test_pattern_select == 3'h0 && link_device_number == 8'h00 && !converter_sleep && lane_count_m1 == 3'h1;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset left a control set");
	property p_busy_pulse;
		soft_reset_busy |=> !soft_reset_busy;
	endproperty
	a_busy_pulse: assert property (p_busy_pulse) else $error("soft reset did not clear");
	property p_idle_stable;
		cs_n [*8] |-> $stable(test_pattern_select) && $stable(link_device_number);
	endproperty
	a_idle_stable: assert property (p_idle_stable) else $error("control changed while idle");
endmodule // adc_spi_config_port_chk
bind adc_spi_config_port adc_spi_config_port_chk u_adc_spi_config_port_chk (.clk, .sys_rst, .cs_n, .sck, .sdo_o,
	.sdo_oe, .converter_sleep, .channels_nap, .clock_halving_select, .lane_count_m1, .frames_per_multiframe_m1,
	.test_pattern_select, .link_device_number, .soft_reset_busy);
`default_nettype wire

// >>> sim/spi_host_model.sv
// Serial bus master standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// Serial pins
	output logic cs_n,
	output logic sck,
	output logic sdi,
	// Open-drain line from the port
	input wire logic sdo_oe
);
	logic sdo_line;
	// External pull-up: a released line reads high
	assign sdo_line = sdo_oe ? 1'b0 : 1'b1;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end
	// Bits past the sixteenth are ones so a stray capture would show
	task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		sck = 1'b0;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			sdi = (i < 16) ? w[15 - i] : 1'b1;
			#62.5;
			sck = 1'b1;
			if (i >= 8 && i < 16)
				rd = {rd[6:0], sdo_line};
			#62.5;
			sck = 1'b0;
		end
		#62.5;
		cs_n = 1'b1;
		sdi = ~sdi;
		#100;
	endtask
endmodule // spi_host_model
`default_nettype wire

// >>> sim/tb_adc_spi_config_port.sv
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`default_nettype none
module tb_adc_spi_config_port;
	import cfg_port_pkg::*;
	logic clk;
	logic sys_rst;
	wire logic cs_n;
	wire logic sck;
	wire logic sdi;
	logic sdo_o, sdo_oe, converter_sleep, channels_nap, channel_b_off, channel_a_off;
	logic clock_halving_select, overflow_output_enable, duty_stabilizer_enable;
	logic [7:0] link_device_number;
	logic [3:0] link_bank_number;
	logic [2:0] lane_count_m1;
	logic [4:0] frames_per_multiframe_m1;
	logic align_sequence_off, lane_monitor_off, frame_monitor_off, divider_resync_off, scrambler_on;
	logic [7:0] link_subclass_options;
	logic [2:0] test_pattern_select;
	logic [1:0] output_swing_select;
	logic soft_reset_busy;
	int busy_count = 0;
	logic [7:0] got;
	int miscompares;
	int n_compared;
	logic [7:0] dflt [0:12] = '{READ_ALL_ONES, DEF_POWER_DOWN, DEF_CLK_OPTS, DEF_DEV_NUM, DEF_BANK_NUM, DEF_LANES,
		DEF_MFRAME, DEF_LINK_MODE, DEF_SUBCLASS, DEF_PATTERN, DEF_SWING, 8'h00, 8'h00};
	logic [7:0] mask [0:12] = '{8'h00, MASK_POWER_DOWN, MASK_CLK_OPTS, MASK_DEV_NUM, MASK_BANK_NUM, MASK_LANES,
		MASK_MFRAME, MASK_LINK_MODE, MASK_SUBCLASS, MASK_PATTERN, MASK_SWING, 8'h00, 8'h00};

	adc_spi_config_port u_adc_spi_config_port (
		.clk(clk),
		.sys_rst(sys_rst),
		.cs_n(cs_n),
		.sck(sck),
		.sdi(sdi),
		.sdo_o(sdo_o),
		.sdo_oe(sdo_oe),
		.converter_sleep(converter_sleep),
		.channels_nap(channels_nap),
		.channel_b_off(channel_b_off),
		.channel_a_off(channel_a_off),
		.clock_halving_select(clock_halving_select),
		.overflow_output_enable(overflow_output_enable),
		.duty_stabilizer_enable(duty_stabilizer_enable),
		.link_device_number(link_device_number),
		.link_bank_number(link_bank_number),
		.lane_count_m1(lane_count_m1),
		.frames_per_multiframe_m1(frames_per_multiframe_m1),
		.align_sequence_off(align_sequence_off),
		.lane_monitor_off(lane_monitor_off),
		.frame_monitor_off(frame_monitor_off),
		.divider_resync_off(divider_resync_off),
		.scrambler_on(scrambler_on),
		.link_subclass_options(link_subclass_options),
		.test_pattern_select(test_pattern_select),
		.output_swing_select(output_swing_select),
		.soft_reset_busy(soft_reset_busy)
	);
	spi_host_model u_spi_host_model (
		.cs_n(cs_n),
		.sck(sck),
		.sdi(sdi),
		.sdo_oe(sdo_oe)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (soft_reset_busy === 1'b1)
			busy_count <= busy_count + 1;

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_spi_host_model.xfer({1'b0, a, d}, 16, got);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		u_spi_host_model.xfer({1'b1, a, 8'h00}, 16, got);
		check("read", got, exp);
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic t_defaults();
		for (int a = 0; a < 13; a++)
			rd(a[6:0], dflt[a]);
	endtask
	// A value with unequal nibbles catches field position slips; it reads the same bit-reversed, so bit order slips pass
	task automatic t_write_all();
		for (int a = 1; a < 13; a++)
			wr(a[6:0], 8'hA5);
		for (int a = 0; a < 13; a++)
			rd(a[6:0], (a == 0) ? 8'hFF : (8'hA5 & mask[a]));
		check("pd", {4'h0, converter_sleep, channels_nap, channel_b_off, channel_a_off}, 8'h05);
		check("ck", {5'h0, clock_halving_select, overflow_output_enable, duty_stabilizer_enable}, 8'h05);
		check("lanes", {5'h0, lane_count_m1}, 8'h05);
		check("mf", {3'h0, frames_per_multiframe_m1}, 8'h05);
		check("dev", link_device_number, 8'hA5);
		check("bank", {link_bank_number, 2'h0, output_swing_select}, 8'h51);
		check("mode", {2'h0, align_sequence_off, lane_monitor_off, frame_monitor_off, 1'b0, divider_resync_off,
			scrambler_on}, 8'h21);
		check("sub", link_subclass_options, 8'hA5);
		wr(ADDR_POWER_DOWN, 8'h0A);
		check("pd2", {4'h0, converter_sleep, channels_nap, channel_b_off, channel_a_off}, 8'h0A);
	endtask
	task automatic t_patterns();
		for (int p = 0; p < 8; p++) begin
			wr(ADDR_PATTERN, p[7:0]);
			check("pat", {5'h0, test_pattern_select}, p[7:0]);
		end
	endtask
	task automatic t_read_ignores();
		wr(ADDR_DEV_NUM, 8'h3C);
		u_spi_host_model.xfer({1'b1, ADDR_DEV_NUM, 8'hFF}, 16, got);
		check("rd_sdi", got, 8'h3C);
		rd(ADDR_DEV_NUM, 8'h3C);
	endtask
	task automatic t_edges();
		u_spi_host_model.xfer({1'b0, ADDR_BANK_NUM, 8'h06}, 24, got);
		rd(ADDR_BANK_NUM, 8'h06);
		check("bank", {4'h0, link_bank_number}, 8'h06);
		u_spi_host_model.xfer({1'b0, ADDR_BANK_NUM, 8'h09}, 12, got);
		rd(ADDR_BANK_NUM, 8'h06);
	endtask
	task automatic t_soft_reset();
		int base;
		wr(ADDR_LANES, 8'h03);
		base = busy_count;
		wr(ADDR_SOFT_RESET, 8'h80);
		check("busy", 8'(busy_count - base), 8'h01);
		check("lanes", {5'h0, lane_count_m1}, DEF_LANES);
		rd(ADDR_SOFT_RESET, 8'hFF);
		rd(ADDR_PATTERN, DEF_PATTERN);
		wr(ADDR_PATTERN, 8'h02);
		rd(ADDR_PATTERN, 8'h02);
		check("sdo", {7'h0, sdo_o}, 8'h00);
	endtask

	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
	initial begin
		sys_rst = 1'b1;
		miscompares = 0;
		n_compared = 0;
		repeat (10) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		t_defaults();
		t_write_all();
		t_patterns();
		t_read_ignores();
		t_edges();
		t_soft_reset();
		end_of_test();
	end
endmodule // tb_adc_spi_config_port
`default_nettype wire
